// ==== include/atc_pkg.sv ====
// Package of constants and types for the alert tone cadence sequencer.
package atc_pkg;

  // ----------------------------------------------------------------------
  // Clock and time base
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_HZ      = 25000000;
  localparam int unsigned MS_TIME     = 1;
  localparam int unsigned MS_CYCLES   = CLK_HZ / 1000 * MS_TIME;
  localparam int unsigned MS_CNT_W    = 15;

  // ----------------------------------------------------------------------
  // Tone times in milliseconds
  // ----------------------------------------------------------------------
  localparam logic [12:0] CLICK_MS    = 13'd50;
  localparam logic [12:0] BUZZ_MS     = 13'd150;
  localparam logic [12:0] HARD_MS     = 13'd150;
  localparam logic [12:0] FAIL_MS     = 13'd370;
  localparam logic [12:0] PIP_MS      = 13'd100;
  localparam logic [12:0] BLIP_MS     = 13'd370;
  localparam logic [12:0] RING_MS     = 13'd500;
  localparam logic [12:0] LONG_MS     = 13'd5000;
  localparam logic [12:0] PIP_RPT_MS  = 13'd6000;
  localparam logic [12:0] UK_RPT_MS   = 13'd4000;
  localparam logic [12:0] FR_RPT_MS   = 13'd6000;
  localparam logic [12:0] FR_BURST_MS = 13'd1000;
  localparam int unsigned TIME_W      = 13;

  // ----------------------------------------------------------------------
  // Tone types and pitch selects
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    TONE_NONE, TONE_CLICK, TONE_BUZZ, TONE_HARD, TONE_UNOBT, TONE_FAIL,
    TONE_PIP, TONE_PIP_RPT, TONE_BLIP, TONE_RING_UK, TONE_RING_FR
  } atc_tone_e;

  typedef enum logic [1:0] {
    PITCH_400, PITCH_800, PITCH_1500
  } atc_pitch_e;

endpackage : atc_pkg

// ==== include/atc_tick_if.sv ====
// Interface carrying the millisecond time base between sequencer modules.
`timescale 1ns/1ps
interface atc_tick_if;
  logic restart;
  logic ms_tick;
  modport src (input restart, output ms_tick);
  modport dst (output restart, input ms_tick);
endinterface : atc_tick_if

// ==== rtl/atc_ms_timer.sv ====
// Millisecond enable divider for the alert tone sequencer.
`timescale 1ns/1ps
module atc_ms_timer (
  input  wire logic clk,
  input  wire logic rst,
  atc_tick_if.src   tick
);

  logic [atc_pkg::MS_CNT_W-1:0] cnt;
  logic [atc_pkg::MS_CNT_W-1:0] next_cnt;
  logic                         pulse;
  logic                         next_pulse;

  // Restart realigns the time base so a new pattern gets full first periods.
  always_comb begin
    next_cnt   = cnt + 1'b1;
    next_pulse = 1'b0;
    if (tick.restart) begin
      next_cnt = '0;
    end else if (cnt == atc_pkg::MS_CNT_W'(atc_pkg::MS_CYCLES - 1)) begin
      next_cnt   = '0;
      next_pulse = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt   <= '0;
      pulse <= 1'b0;
    end else begin
      cnt   <= next_cnt;
      pulse <= next_pulse;
    end
  end

  assign tick.ms_tick = pulse;

endmodule : atc_ms_timer

// ==== rtl/atc_sequencer.sv ====
// Alert tone cadence sequencer: pitch select and gate for the RC oscillator.
`timescale 1ns/1ps
module atc_sequencer #(
  parameter logic [12:0] FR_BURST_MS = atc_pkg::FR_BURST_MS
) (
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic                tone_req,
  input  wire atc_pkg::atc_tone_e  tone_type,
  input  wire logic                on_hook,
  input  wire logic                terminate,
  output atc_pkg::atc_pitch_e      pitch_sel,
  output logic                     tone_gate_output,
  output logic                     busy
);

  // ----------------------------------------------------------------------
  // Time base
  // ----------------------------------------------------------------------
  atc_tick_if tick ();

  atc_ms_timer u_timer (
    .clk  (clk),
    .rst  (rst),
    .tick (tick)
  );

  // ----------------------------------------------------------------------
  // Pattern description per tone type
  // ----------------------------------------------------------------------
  // Each pattern is: bursts of on_ms separated by gaps of off_ms, nburst bursts per
  // group; a group restarts every period_ms (zero means no repeat); the whole
  // pattern ends at total_ms (zero means no overall limit).
  typedef struct packed {
    atc_pkg::atc_pitch_e pitch;
    logic [12:0]         on_ms;
    logic [12:0]         off_ms;
    logic [1:0]          nburst;
    logic [12:0]         period_ms;
    logic [12:0]         total_ms;
    logic                hook_stop;
    logic                term_stop;
  } atc_pat_s;

  function automatic atc_pat_s pattern(input atc_pkg::atc_tone_e t);
    atc_pat_s p;
    p = '{atc_pkg::PITCH_400, 13'd0, 13'd0, 2'd0, 13'd0, 13'd0, 1'b0, 1'b0};
    case (t)
      atc_pkg::TONE_CLICK: begin
        p = '{atc_pkg::PITCH_1500, atc_pkg::CLICK_MS, 13'd0, 2'd1, 13'd0, 13'd0,
              1'b0, 1'b0};
      end
      atc_pkg::TONE_BUZZ: begin
        p = '{atc_pkg::PITCH_400, atc_pkg::BUZZ_MS, 13'd0, 2'd1, 13'd0, 13'd0, 1'b0, 1'b0};
      end
      atc_pkg::TONE_HARD: begin
        p = '{atc_pkg::PITCH_400, atc_pkg::HARD_MS, atc_pkg::HARD_MS, 2'd1,
              atc_pkg::HARD_MS + atc_pkg::HARD_MS, atc_pkg::LONG_MS, 1'b0, 1'b0};
      end
      atc_pkg::TONE_UNOBT: begin
        p = '{atc_pkg::PITCH_400, atc_pkg::LONG_MS, 13'd0, 2'd1, 13'd0,
              atc_pkg::LONG_MS, 1'b1, 1'b0};
      end
      atc_pkg::TONE_FAIL: begin
        p = '{atc_pkg::PITCH_400, atc_pkg::FAIL_MS, atc_pkg::FAIL_MS, 2'd1,
              atc_pkg::FAIL_MS + atc_pkg::FAIL_MS, atc_pkg::LONG_MS, 1'b1, 1'b0};
      end
      atc_pkg::TONE_PIP: begin
        p = '{atc_pkg::PITCH_400, atc_pkg::PIP_MS, atc_pkg::PIP_MS, 2'd2, 13'd0,
              13'd0, 1'b0, 1'b0};
      end
      atc_pkg::TONE_PIP_RPT: begin
        p = '{atc_pkg::PITCH_400, atc_pkg::PIP_MS, atc_pkg::PIP_MS, 2'd2,
              atc_pkg::PIP_RPT_MS, 13'd0, 1'b0, 1'b1};
      end
      atc_pkg::TONE_BLIP: begin
        p = '{atc_pkg::PITCH_800, atc_pkg::BLIP_MS, 13'd0, 2'd1, 13'd0, 13'd0, 1'b0, 1'b0};
      end
      atc_pkg::TONE_RING_UK: begin
        p = '{atc_pkg::PITCH_800, atc_pkg::RING_MS, atc_pkg::RING_MS, 2'd2,
              atc_pkg::UK_RPT_MS, 13'd0, 1'b0, 1'b1};
      end
      atc_pkg::TONE_RING_FR: begin
        p = '{atc_pkg::PITCH_800, FR_BURST_MS, 13'd0, 2'd1, atc_pkg::FR_RPT_MS,
              13'd0, 1'b0, 1'b1};
      end
      default: begin
        p.nburst = 2'd0;
      end
    endcase
    return p;
  endfunction : pattern

  // ----------------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE, ST_ON, ST_OFF, ST_WAIT
  } atc_state_e;

  atc_state_e          state;
  atc_state_e          next_state;
  atc_pat_s            pat;
  atc_pat_s            next_pat;
  logic [12:0]         phase_ms;
  logic [12:0]         next_phase_ms;
  logic [12:0]         group_ms;
  logic [12:0]         next_group_ms;
  logic [12:0]         total_ms;
  logic [12:0]         next_total_ms;
  logic [1:0]          bursts;
  logic [1:0]          next_bursts;
  atc_pkg::atc_pitch_e next_pitch;
  logic                next_gate;
  atc_pat_s            req_pat;
  logic                cancel;
  logic                total_done;

  assign req_pat    = pattern(tone_type);
  assign cancel     = (pat.hook_stop && on_hook) || (pat.term_stop && terminate);
  assign total_done = (pat.total_ms != 13'd0) && (total_ms == pat.total_ms - 13'd1);

  // The time base restarts on every new request so the first burst is exact.
  assign tick.restart = tone_req;

  always_comb begin
    next_state    = state;
    next_pat      = pat;
    next_phase_ms = phase_ms;
    next_group_ms = group_ms;
    next_total_ms = total_ms;
    next_bursts   = bursts;
    next_pitch    = pitch_sel;
    if (tone_req) begin
      // A new request always wins, even over a cancel in the same cycle.
      next_pat      = req_pat;
      next_pitch    = req_pat.pitch;
      next_phase_ms = '0;
      next_group_ms = '0;
      next_total_ms = '0;
      next_bursts   = 2'd1;
      next_state    = (req_pat.nburst == 2'd0) ? ST_IDLE : ST_ON;
    end else if (state != ST_IDLE && cancel) begin
      next_state = ST_IDLE;
    end else if (state != ST_IDLE && tick.ms_tick) begin
      next_phase_ms = phase_ms + 13'd1;
      next_group_ms = group_ms + 13'd1;
      next_total_ms = total_ms + 13'd1;
      if (total_done) begin
        next_state = ST_IDLE;
      end else if (pat.period_ms != 13'd0 && group_ms == pat.period_ms - 13'd1) begin
        next_state    = ST_ON;
        next_phase_ms = '0;
        next_group_ms = '0;
        next_bursts   = 2'd1;
      end else begin
        case (state)
          ST_ON: begin
            if (phase_ms == pat.on_ms - 13'd1) begin
              next_phase_ms = '0;
              if (bursts != pat.nburst) begin
                next_state = ST_OFF;
              end else if (pat.period_ms != 13'd0) begin
                next_state = ST_WAIT;
              end else if (pat.total_ms != 13'd0) begin
                next_state = ST_ON; // Unbroken tone holds until the total ends.
              end else begin
                next_state = ST_IDLE;
              end
            end
          end
          ST_OFF: begin
            if (phase_ms == pat.off_ms - 13'd1) begin
              next_phase_ms = '0;
              next_bursts   = bursts + 2'd1;
              next_state    = ST_ON;
            end
          end
          default: begin
            next_state = state;
          end
        endcase
      end
    end
  end

  // The gate is the only switch of the tone; the pitch merely selects.
  always_comb begin
    next_gate = (next_state == ST_ON);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state            <= ST_IDLE;
      pat              <= '0;
      phase_ms         <= '0;
      group_ms         <= '0;
      total_ms         <= '0;
      bursts           <= '0;
      pitch_sel        <= atc_pkg::PITCH_400;
      tone_gate_output <= 1'b0;
    end else begin
      state            <= next_state;
      pat              <= next_pat;
      phase_ms         <= next_phase_ms;
      group_ms         <= next_group_ms;
      total_ms         <= next_total_ms;
      bursts           <= next_bursts;
      pitch_sel        <= next_pitch;
      tone_gate_output <= next_gate;
    end
  end

  assign busy = (state != ST_IDLE);

endmodule : atc_sequencer

// ==== bench/atc_props.sv ====
// Port checker for the alert tone sequencer.
`timescale 1ns/1ps
module atc_props (
  input wire logic                clk,
  input wire logic                rst,
  input wire logic                tone_req,
  input wire atc_pkg::atc_tone_e  tone_type,
  input wire logic                on_hook,
  input wire logic                terminate,
  input wire atc_pkg::atc_pitch_e pitch_sel,
  input wire logic                tone_gate_output,
  input wire logic                busy
);
  // -----------------------------------------------------------------
  // Running type, since cancels only act on the types that use them.
  // -----------------------------------------------------------------
  atc_pkg::atc_tone_e cur;
  atc_pkg::atc_tone_e next_cur;
  always_comb next_cur = tone_req ? tone_type : cur;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) cur <= atc_pkg::TONE_NONE;
    else cur <= next_cur;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_start;
    tone_req && tone_type != atc_pkg::TONE_NONE |=> tone_gate_output && busy;
  endproperty
  a_start: assert property (p_start) else $error("gate not raised");
  property p_none;
    tone_req && tone_type == atc_pkg::TONE_NONE |=> !tone_gate_output && !busy;
  endproperty
  a_none: assert property (p_none) else $error("abort left tone on");
  property p_hi;
    tone_req && tone_type == atc_pkg::TONE_CLICK |=> pitch_sel == atc_pkg::PITCH_1500;
  endproperty
  a_hi: assert property (p_hi) else $error("click pitch wrong");
  property p_low;
    tone_req && tone_type inside {atc_pkg::TONE_BUZZ, atc_pkg::TONE_HARD,
      atc_pkg::TONE_UNOBT, atc_pkg::TONE_FAIL, atc_pkg::TONE_PIP, atc_pkg::TONE_PIP_RPT}
      |=> pitch_sel == atc_pkg::PITCH_400;
  endproperty
  a_low: assert property (p_low) else $error("low pitch wrong");
  property p_mid;
    tone_req && tone_type inside {atc_pkg::TONE_BLIP, atc_pkg::TONE_RING_UK,
      atc_pkg::TONE_RING_FR} |=> pitch_sel == atc_pkg::PITCH_800;
  endproperty
  a_mid: assert property (p_mid) else $error("mid pitch wrong");
  property p_hook;
    !tone_req && on_hook && cur inside {atc_pkg::TONE_UNOBT, atc_pkg::TONE_FAIL}
      |=> !tone_gate_output && !busy;
  endproperty
  a_hook: assert property (p_hook) else $error("on-hook ignored");
  property p_term;
    !tone_req && terminate && cur inside {atc_pkg::TONE_PIP_RPT, atc_pkg::TONE_RING_UK,
      atc_pkg::TONE_RING_FR} |=> !tone_gate_output && !busy;
  endproperty
  a_term: assert property (p_term) else $error("terminate ignored");
  property p_hold;
    !tone_req |=> $stable(pitch_sel);
  endproperty
  a_hold: assert property (p_hold) else $error("pitch moved");
endmodule : atc_props
bind atc_sequencer atc_props chk_u (.clk(clk), .rst(rst), .tone_req(tone_req),
  .tone_type(tone_type), .on_hook(on_hook), .terminate(terminate),
  .pitch_sel(pitch_sel), .tone_gate_output(tone_gate_output), .busy(busy));

// ==== bench/atc_osc_model.sv ====
// Behavioural model of the gated RC tone oscillator.
`timescale 1ns/1ps
module atc_osc_model (
  input  wire logic                clk,
  input  wire atc_pkg::atc_pitch_e pitch_sel,
  input  wire logic                tone_gate_output,
  output int                       freq_hz,
  output logic                     audio
);
  int half;
  int cnt = 0;
  initial audio = 1'b0;
  // -----------------------------------------------------------------
  // Pitch only retunes the network; sound passes only through the gate.
  // -----------------------------------------------------------------
  always_comb begin
    case (pitch_sel)
      atc_pkg::PITCH_800:  half = 15625;
      atc_pkg::PITCH_1500: half = 8333;
      default:             half = 31250;
    endcase
    freq_hz = tone_gate_output ? 12500000 / half : 0;
  end
  always @(posedge clk) begin
    cnt <= (!tone_gate_output || cnt >= half - 1) ? 0 : cnt + 1;
    audio <= !tone_gate_output ? 1'b0 : (cnt >= half - 1) ? ~audio : audio;
  end
endmodule : atc_osc_model

// ==== bench/tb_top.sv ====
// Self-checking testbench of the alert tone cadence sequencer.
`timescale 1ns/1ps
module tb_top;
  logic                clk = 1'b0;
  logic                rst = 1'b1;
  logic                tone_req = 1'b0;
  atc_pkg::atc_tone_e  tone_type = atc_pkg::TONE_NONE;
  logic                on_hook = 1'b0;
  logic                terminate = 1'b0;
  atc_pkg::atc_pitch_e pitch_sel;
  logic                gate;
  logic                busy;
  int                  freq_hz;
  int                  err_total = 0;
  int                  n_compared = 0;
  int                  cycles = 0;
  initial forever #20 clk = ~clk;
  // A one millisecond French burst keeps the whole run short.
  atc_sequencer #(.FR_BURST_MS(13'h001)) dut_u (.clk(clk), .rst(rst),
    .tone_req(tone_req), .tone_type(tone_type), .on_hook(on_hook), .terminate(terminate),
    .pitch_sel(pitch_sel), .tone_gate_output(gate), .busy(busy));
  atc_osc_model osc_u (.clk(clk), .pitch_sel(pitch_sel), .tone_gate_output(gate),
    .freq_hz(freq_hz), .audio());
  // -----------------------------------------------------------------
  // Shared tasks.
  // -----------------------------------------------------------------
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, got);
    end
  endtask : chk
  task automatic req(atc_pkg::atc_tone_e t);
    @(negedge clk);
    tone_req = 1'b1;
    tone_type = t;
    @(negedge clk);
    tone_req = 1'b0;
  endtask : req
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  // -----------------------------------------------------------------
  // Scenarios.
  // -----------------------------------------------------------------
  task automatic t_types();
    atc_pkg::atc_tone_e t;
    int hz;
    for (int i = 1; i <= 10; i++) begin
      t = atc_pkg::atc_tone_e'(i);
      hz = (t == atc_pkg::TONE_CLICK) ? 1500 : (i >= 8) ? 800 : 400;
      req(t);
      chk("gate", 16'h0001, {15'h0, gate});
      chk("busy", 16'h0001, {15'h0, busy});
      chk("pitch", hz[15:0], freq_hz[15:0]);
    end
    req(atc_pkg::TONE_NONE);
    chk("abort gate", 16'h0000, {15'h0, gate});
    chk("abort pitch", 16'h0000, {14'h0, pitch_sel});
    $display("tone type test done");
  endtask : t_types
  task automatic t_cancel(atc_pkg::atc_tone_e t, logic hook, logic stop);
    req(t);
    repeat (5) @(negedge clk);
    on_hook = hook;
    terminate = !hook;
    @(negedge clk);
    chk("gate after cancel", {15'h0, !stop}, {15'h0, gate});
    chk("busy after cancel", {15'h0, !stop}, {15'h0, busy});
    on_hook = 1'b0;
    terminate = 1'b0;
    $display("cancel test of type %0d done", t);
  endtask : t_cancel
  // An incoming call is announced to the user by the double pip.
  task automatic t_incoming();
    req(atc_pkg::TONE_PIP);
    chk("incoming gate", 16'h0001, {15'h0, gate});
    chk("incoming pitch", 16'h0190, freq_hz[15:0]);
    $display("incoming call test done");
  endtask : t_incoming
  task automatic t_fr_burst();
    int n = 0;
    req(atc_pkg::TONE_RING_FR);
    while (gate === 1'b1 && n < 30000) begin
      n++;
      @(negedge clk);
    end
    chk("burst ok", 16'h0001, {15'h0, n >= 24999 && n <= 25001});
    chk("wait busy", 16'h0001, {15'h0, busy});
    $display("french burst test done");
  endtask : t_fr_burst
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      err_total++;
      $display("unexpected timeout");
      print_verdict();
    end
  end
  initial begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    chk("reset gate", 16'h0000, {15'h0, gate});
    chk("reset busy", 16'h0000, {15'h0, busy});
    t_types();
    t_incoming();
    t_cancel(atc_pkg::TONE_UNOBT, 1'b1, 1'b1);
    t_cancel(atc_pkg::TONE_FAIL, 1'b1, 1'b1);
    t_cancel(atc_pkg::TONE_PIP_RPT, 1'b0, 1'b1);
    t_cancel(atc_pkg::TONE_RING_UK, 1'b0, 1'b1);
    t_cancel(atc_pkg::TONE_RING_FR, 1'b0, 1'b1);
    t_cancel(atc_pkg::TONE_BUZZ, 1'b1, 1'b0);
    t_cancel(atc_pkg::TONE_UNOBT, 1'b0, 1'b0);
    t_fr_burst();
    print_verdict();
  end
endmodule : tb_top
